// file: src/sbf_pkg.sv
// Package of constants and types for the SDRAM bank access front end
package sbf_pkg;
  localparam int NUM_BANKS = 4;
  localparam int ROW_W = 13;
  localparam int COL_W = 11;
  localparam int DATA_W = 16;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 13;
  // Data organisation per configuration
  localparam int ROWS_PER_BANK = 8192;
  localparam int COLS_X4 = 2048;
  localparam int COLS_X8 = 1024;
  localparam int COLS_X16 = 512;
  localparam logic [1:0] CFG_X4 = 2'h0;
  localparam logic [1:0] CFG_X8 = 2'h1;
  localparam logic [1:0] CFG_X16 = 2'h2;
  // Address field positions
  localparam int PRECHARGE_SELECT_POS = 10;
  localparam int X4_COL_HI_POS = 11;
  localparam int MODE_BURST_COUNT_LSB = 0;
  localparam int MODE_BT_POS = 3;
  localparam int MODE_CL_LSB = 4;
  localparam int MODE_WB_POS = 9;
  localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0030;
  // Latencies and automotive refresh window
  localparam int DQM_READ_LAT = 2;
  localparam int GRADE_REFRESH_MS = 16;
  localparam int CLK_MHZ = 10;
  localparam int GRADE_REFRESH_CYC = GRADE_REFRESH_MS * 1000 * CLK_MHZ;
  localparam int AP_DELAY = 2;
  // Command encodings {cs_n, ras_n, cas_n, we_n}
  typedef enum logic [3:0] {
    CMD_NOP = 4'h7, CMD_ACT = 4'h3, CMD_RD = 4'h5, CMD_WR = 4'h4,
    CMD_BST = 4'h6, CMD_PRE = 4'h2, CMD_REF = 4'h1, CMD_LMR = 4'h0
  } sbf_cmd_t;
endpackage

// file: src/sbf_skid.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module sbf_skid import sbf_pkg::*; (
  input wire logic ref_clk, // Clock
  input wire logic reset, // Synchronous reset
  input wire logic [DATA_W-1:0] in_data, // Filling data
  input wire logic in_valid, // Filling valid
  output logic in_ready, // Room available
  output logic [DATA_W-1:0] out_data, // Draining data
  output logic out_valid, // Draining valid
  input wire logic out_ready // Drain accepts
);
  logic [DATA_W-1:0] out_r, spare_r;
  logic out_v_r, spare_v_r;
  logic push, drain;
  // Outputs come straight from the head register; the spare catches the
  // word that arrives in the cycle the drain side first stalls
  assign push = in_valid && in_ready;
  assign drain = !out_v_r || out_ready;
  assign in_ready = !spare_v_r;
  assign out_data = out_r;
  assign out_valid = out_v_r;
  // Occupancy
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      out_v_r <= 1'b0;
      spare_v_r <= 1'b0;
    end else if (drain) begin
      out_v_r <= spare_v_r || push;
      spare_v_r <= 1'b0;
    end else if (push) begin
      spare_v_r <= 1'b1;
    end
  end
  // Storage, oldest word always in the head
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      out_r <= '0;
      spare_r <= '0;
    end else if (drain) begin
      if (spare_v_r) out_r <= spare_r;
      else if (push) out_r <= in_data;
    end else if (push) begin
      spare_r <= in_data;
    end
  end
endmodule

// file: src/sbf_front_end.sv
// SDRAM bank access front end: command decode, banks, bursts, refresh
`timescale 1ns/1ps
// Function
// - Capture all inputs on rising clock edge
// - x4 banks: 8192 rows, 2048 columns
// - x8 banks: 8192 rows, 1024 columns
// - x16 banks: 8192 rows, 512 columns
// - Every access is a programmed burst
// - Activate picks bank and row
// - Read/write address gives starting column
// - Burst length 1,2,4,8 or page
// - Burst terminate ends any burst
// - Auto precharge after burst ends
// - New column accepted every cycle
// - Precharge one bank while accessing another
// - Following columns generated internally
// - Auto refresh and power-down modes
// - Bit ten selects auto precharge
// - Precharge bit ten closes all banks
// - Chip select high masks commands
// - Mask: reads tristate later, writes blocked
module sbf_front_end import sbf_pkg::*; (
  input wire logic ref_clk, // Clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic [1:0] cfg_width, // Organisation strap
  input wire logic automotive_grade, // Automotive option strap
  input wire logic cke_pin, // Clock enable pin
  input wire logic cs_n_pin, // Chip select, low active
  input wire logic ras_n_pin, // Row strobe, low active
  input wire logic cas_n_pin, // Column strobe, low active
  input wire logic we_n_pin, // Write enable, low active
  input wire logic [BANK_W-1:0] ba_pin, // Bank select
  input wire logic [ADDR_W-1:0] addr_pin, // Address
  input wire logic dqm_pin, // Data mask
  input wire logic [DATA_W-1:0] dq_in, // Data pin input
  output logic [DATA_W-1:0] dq_out, // Data pin output
  output logic dq_oe, // Data pin drive enable
  output logic [DATA_W-1:0] arr_wdata, // Write word to array
  output logic arr_wvalid, // Write word valid
  input wire logic arr_wready, // Array accepts write
  output logic [BANK_W-1:0] arr_bank, // Array bank
  output logic [ROW_W-1:0] arr_row, // Array row
  output logic [COL_W-1:0] arr_col, // Array column
  output logic arr_rd, // Array read strobe
  input wire logic [DATA_W-1:0] arr_rdata, // Array read data
  output logic [NUM_BANKS-1:0] bank_open, // Banks with open row
  output logic [NUM_BANKS-1:0] refresh_pulse, // Refresh issued
  output logic power_down, // In power-down
  output logic refresh_late, // Automotive window missed
  output logic self_refresh_err // Illegal self refresh
);
  // ----------------------------------------
  // Input registers
  // ----------------------------------------
  logic [3:0] cmd_r;
  logic [BANK_W-1:0] ba_r;
  logic [ADDR_W-1:0] a_r;
  logic dqm_r, cke_r, cke_prev_r;
  logic [DATA_W-1:0] din_r;
  // All pins captured once on the rising edge; nothing else looks at them
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmd_r <= CMD_NOP;
      ba_r <= '0;
      a_r <= '0;
      dqm_r <= 1'b0;
      cke_r <= 1'b1;
      cke_prev_r <= 1'b1;
      din_r <= '0;
    end else begin
      cmd_r <= {cs_n_pin, ras_n_pin, cas_n_pin, we_n_pin};
      ba_r <= ba_pin;
      a_r <= addr_pin;
      dqm_r <= dqm_pin;
      cke_r <= cke_pin;
      cke_prev_r <= cke_r;
      din_r <= dq_in;
    end
  end

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic deselect, is_act, is_rd, is_wr, is_bst, is_pre, is_ref, is_lmr, is_sref;
  assign deselect = cmd_r[3];
  assign is_act = cke_r && (cmd_r == CMD_ACT);
  assign is_rd = cke_r && (cmd_r == CMD_RD);
  assign is_wr = cke_r && (cmd_r == CMD_WR);
  assign is_bst = cke_r && (cmd_r == CMD_BST);
  assign is_pre = cke_r && (cmd_r == CMD_PRE);
  assign is_lmr = cke_r && (cmd_r == CMD_LMR);
  assign is_ref = cke_r && cke_prev_r && (cmd_r == CMD_REF);
  assign is_sref = !cke_r && cke_prev_r && (cmd_r == CMD_REF);

  // Column width follows organisation strap
  logic [COL_W-1:0] start_col, col_mask;
  always_comb begin
    case (cfg_width)
      CFG_X4: begin
        start_col = {a_r[X4_COL_HI_POS], a_r[9:0]};
        col_mask = COL_W'(COLS_X4 - 1);
      end
      CFG_X8: begin
        start_col = {1'b0, a_r[9:0]};
        col_mask = COL_W'(COLS_X8 - 1);
      end
      default: begin
        start_col = {2'b00, a_r[8:0]};
        col_mask = COL_W'(COLS_X16 - 1);
      end
    endcase
  end

  // ----------------------------------------
  // Mode register
  // ----------------------------------------
  logic [ADDR_W-1:0] mode_r;
  always_ff @(posedge ref_clk) begin
    if (reset) mode_r <= MODE_RESET;
    else if (is_lmr) mode_r <= a_r;
  end
  // Burst length decode; code 7 is full page, wrapping until terminated
  logic [COL_W:0] blen;
  logic full_page;
  always_comb begin
    full_page = (mode_r[MODE_BURST_COUNT_LSB +: 3] == 3'h7);
    case (mode_r[MODE_BURST_COUNT_LSB +: 3])
      3'h0: blen = 12'h001;
      3'h1: blen = 12'h002;
      3'h2: blen = 12'h004;
      3'h3: blen = 12'h008;
      default: blen = {1'b0, col_mask} + 12'h001;
    endcase
  end

  // ----------------------------------------
  // Bank row tracking and precharge
  // ----------------------------------------
  logic [ROW_W-1:0] row_r [NUM_BANKS];
  logic [NUM_BANKS-1:0] open_r;
  logic ap_fire;
  logic [BANK_W-1:0] ap_bank;
  // Each bank opens and closes on its own, so one may precharge
  // while another streams data
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      open_r <= '0;
      for (int i = 0; i < NUM_BANKS; i++) row_r[i] <= '0;
    end else begin
      for (int i = 0; i < NUM_BANKS; i++) begin
        if (is_act && ba_r == BANK_W'(i)) begin
          open_r[i] <= 1'b1;
          row_r[i] <= a_r;
        end else if (is_pre && (a_r[PRECHARGE_SELECT_POS] || ba_r == BANK_W'(i))) begin
          open_r[i] <= 1'b0;
        end else if (ap_fire && ap_bank == BANK_W'(i)) begin
          open_r[i] <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Burst engine
  // ----------------------------------------
  logic bursting_r, wr_burst_r, ap_r;
  logic [BANK_W-1:0] bb_r;
  logic [COL_W-1:0] bstart_r, bofs_r;
  logic [COL_W:0] bleft_r;
  logic start_ok, last_beat;
  // The controller must activate first; an access to a closed bank is dropped
  assign start_ok = (is_rd || is_wr) && open_r[ba_r];
  assign last_beat = bursting_r && !full_page && (bleft_r == 12'h001);
  // A new read or write replaces the running burst at once
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bursting_r <= 1'b0;
      wr_burst_r <= 1'b0;
      ap_r <= 1'b0;
      bb_r <= '0;
      bstart_r <= '0;
      bofs_r <= '0;
      bleft_r <= '0;
    end else if (start_ok) begin
      bursting_r <= 1'b1;
      wr_burst_r <= is_wr;
      ap_r <= a_r[PRECHARGE_SELECT_POS];
      bb_r <= ba_r;
      bstart_r <= start_col;
      bofs_r <= '0;
      bleft_r <= blen;
    end else if (is_bst || (is_pre && (a_r[PRECHARGE_SELECT_POS] || ba_r == bb_r))) begin
      bursting_r <= 1'b0;
      ap_r <= 1'b0;
    end else if (bursting_r) begin // Pins cannot be held, so beats never stall
      bofs_r <= (bofs_r + 1'b1) & col_mask;
      bleft_r <= bleft_r - 1'b1;
      if (last_beat) begin
        bursting_r <= 1'b0;
        ap_r <= 1'b0;
      end
    end
  end

  // Column sequence: sequential or interleaved wrap within the burst block
  logic [COL_W-1:0] cur_col, blk_mask;
  always_comb begin
    blk_mask = full_page ? col_mask : COL_W'(blen - 12'h001);
    if (mode_r[MODE_BT_POS])
      cur_col = (bstart_r & ~blk_mask) | ((bstart_r ^ bofs_r) & blk_mask);
    else
      cur_col = (bstart_r & ~blk_mask) | ((bstart_r + bofs_r) & blk_mask);
  end

  // Self-timed precharge after the last beat of an auto precharge burst
  logic [1:0] ap_cnt_r;
  logic ap_pend_r;
  logic [BANK_W-1:0] ap_bank_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ap_pend_r <= 1'b0;
      ap_cnt_r <= '0;
      ap_bank_r <= '0;
    end else if (last_beat && ap_r) begin
      ap_pend_r <= 1'b1;
      ap_cnt_r <= 2'(AP_DELAY);
      ap_bank_r <= bb_r;
    end else if (ap_pend_r) begin
      ap_cnt_r <= ap_cnt_r - 2'h1;
      if (ap_cnt_r == 2'h1) ap_pend_r <= 1'b0;
    end
  end
  assign ap_fire = ap_pend_r && (ap_cnt_r == 2'h1);
  assign ap_bank = ap_bank_r;

  // ----------------------------------------
  // Write path through the two-entry buffer
  // ----------------------------------------
  logic wr_beat, wmask_r;
  logic [DATA_W-1:0] wdat_r;
  // Write data comes with the command, a cycle before the burst's first beat,
  // so data and mask wait one more stage to meet their beat
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wdat_r <= '0;
      wmask_r <= 1'b0;
    end else begin
      wdat_r <= din_r;
      wmask_r <= dqm_r;
    end
  end
  // Masked words are dropped before the buffer; a receiver stall longer
  // than two words loses the overflow, since the pins cannot be held
  assign wr_beat = bursting_r && wr_burst_r && !wmask_r;
  sbf_skid u_wbuf (
    .ref_clk(ref_clk),
    .reset(reset),
    .in_data(wdat_r),
    .in_valid(wr_beat),
    .in_ready(),
    .out_data(arr_wdata),
    .out_valid(arr_wvalid),
    .out_ready(arr_wready)
  );

  // ----------------------------------------
  // Array address and read strobe
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      arr_bank <= '0;
      arr_row <= '0;
      arr_col <= '0;
      arr_rd <= 1'b0;
    end else begin
      arr_bank <= bb_r;
      arr_row <= row_r[bb_r];
      arr_col <= cur_col;
      arr_rd <= bursting_r && !wr_burst_r;
    end
  end

  // ----------------------------------------
  // Read output with mask latency of two clocks
  // ----------------------------------------
  logic [DQM_READ_LAT-1:0] dqm_pipe_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dqm_pipe_r <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
    end else begin
      dqm_pipe_r <= {dqm_pipe_r[DQM_READ_LAT-2:0], dqm_r};
      dq_out <= arr_rdata;
      dq_oe <= arr_rd && !dqm_pipe_r[DQM_READ_LAT-2];
    end
  end

  // ----------------------------------------
  // Refresh, power-down and automotive checks
  // ----------------------------------------
  logic [31:0] ref_age_r;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      refresh_pulse <= '0;
      power_down <= 1'b0;
      bank_open <= '0;
    end else begin
      refresh_pulse <= (is_ref && open_r == '0) ? '1 : '0;
      power_down <= !cke_r && !bursting_r;
      bank_open <= open_r;
    end
  end
  // Refresh age watch; only meaningful when the strap selects automotive
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ref_age_r <= '0;
      refresh_late <= 1'b0;
      self_refresh_err <= 1'b0;
    end else begin
      ref_age_r <= is_ref ? '0 : ref_age_r + 32'h1;
      refresh_late <= automotive_grade && (ref_age_r >= 32'(GRADE_REFRESH_CYC));
      self_refresh_err <= self_refresh_err || (automotive_grade && is_sref);
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_pre_all;
    is_pre && a_r[PRECHARGE_SELECT_POS];
  endsequence
  a_pre_all_close: assert property (@(posedge ref_clk) disable iff (reset)
    s_pre_all |=> (open_r == '0)) else $error("precharge all left a bank open");
  a_act_opens: assert property (@(posedge ref_clk) disable iff (reset)
    is_act |=> open_r[$past(ba_r)]) else $error("activate did not open bank");
  a_closed_no_burst: assert property (@(posedge ref_clk) disable iff (reset)
    (is_rd && !open_r[ba_r] && !bursting_r) |=> !bursting_r) else $error("burst on closed bank");
  a_bst_stops: assert property (@(posedge ref_clk) disable iff (reset)
    (is_bst && !start_ok) |=> !bursting_r) else $error("terminate did not stop burst");
  a_ap_closes: assert property (@(posedge ref_clk) disable iff (reset)
    (last_beat && ap_r && !start_ok && !is_bst && !is_pre) |-> ##3 !open_r[$past(bb_r, 3)])
    else $error("auto precharge did not close");
  a_deselect_mask: assert property (@(posedge ref_clk) disable iff (reset)
    deselect |-> !(is_act || is_rd || is_wr || is_pre || is_ref)) else $error("command while deselected");
  a_rd_start: assert property (@(posedge ref_clk) disable iff (reset)
    (start_ok && is_rd) |=> (bstart_r == $past(start_col)) && bursting_r) else $error("bad start column");
  a_dqm_tristate: assert property (@(posedge ref_clk) disable iff (reset)
    dqm_r |-> ##2 !dq_oe) else $error("read mask latency wrong");
  a_one_beat: assert property (@(posedge ref_clk) disable iff (reset)
    (start_ok && is_rd && mode_r[2:0] == 3'h0 && cke_r) ##1 (!start_ok && !is_bst && !is_pre)
    |=> !bursting_r) else $error("length one burst ran on");
endmodule

// file: sim/sbf_ctrl_model.sv
// Behavioural memory controller driving the front end's command and data pins
`timescale 1ns/1ps
module sbf_ctrl_model import sbf_pkg::*; (
  input wire logic ref_clk, // Clock
  output logic cke, // Clock enable
  output logic [3:0] cmd, // {cs_n, ras_n, cas_n, we_n}
  output logic [BANK_W-1:0] ba, // Bank select
  output logic [ADDR_W-1:0] addr, // Address
  output logic dqm, // Data mask
  output logic [DATA_W-1:0] dq // Write data
);
  // ----------------------------------------
  // Pin driving
  // ----------------------------------------
  // Deselected at time zero so nothing decodes during reset
  initial begin
    cke = 1'b1;
    cmd = 4'hF;
    ba = 2'h0;
    addr = 13'h0000;
    dqm = 1'b0;
    dq = 16'h0000;
  end
  // One command for one cycle, launched just after a falling edge
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
                       input logic m, input logic [15:0] d, input logic k);
    @(negedge ref_clk);
    cke <= k;
    cmd <= c;
    ba <= b;
    addr <= a;
    dqm <= m;
    dq <= d;
  endtask
  // Idle cycle; address and data are no longer held, so show the inverse
  task automatic idle();
    @(negedge ref_clk);
    cmd <= CMD_NOP;
    addr <= ~addr;
    dq <= ~dq;
    dqm <= 1'b0;
  endtask
endmodule

// file: sim/sbf_front_end_test.sv
// Self-checking testbench for the SDRAM bank access front end
`timescale 1ns/1ps
module sbf_front_end_test import sbf_pkg::*;;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic automotive_grade = 1'b0;
  logic arr_wready = 1'b1;
  logic [1:0] cfg_width = CFG_X16;
  logic [15:0] arr_rdata = 16'h0000;
  logic cke, dqm, arr_wvalid, arr_rd, dq_oe, power_down, refresh_late, self_refresh_err;
  logic ref_seen = 1'b0;
  logic [3:0] pin_cmd, bank_open, refresh_pulse;
  logic [1:0] ba, arr_bank;
  logic [12:0] addr, arr_row;
  logic [10:0] arr_col;
  logic [15:0] dq, dq_out, arr_wdata;
  logic [15:0] cols[$];
  logic [15:0] wq[$];
  int fail_count = 0;
  int n_compared = 0;
  // ----------------------------------------
  // Clock, partner and device
  // ----------------------------------------
  always #50 ref_clk = ~ref_clk;
  sbf_ctrl_model ctl (.ref_clk(ref_clk), .cke(cke), .cmd(pin_cmd), .ba(ba), .addr(addr), .dqm(dqm), .dq(dq));
  sbf_front_end dut (.ref_clk(ref_clk), .reset(reset), .cfg_width(cfg_width),
    .automotive_grade(automotive_grade), .cke_pin(cke), .cs_n_pin(pin_cmd[3]), .ras_n_pin(pin_cmd[2]),
    .cas_n_pin(pin_cmd[1]), .we_n_pin(pin_cmd[0]), .ba_pin(ba), .addr_pin(addr), .dqm_pin(dqm),
    .dq_in(dq), .dq_out(dq_out), .dq_oe(dq_oe), .arr_wdata(arr_wdata), .arr_wvalid(arr_wvalid),
    .arr_wready(arr_wready), .arr_bank(arr_bank), .arr_row(arr_row), .arr_col(arr_col),
    .arr_rd(arr_rd), .arr_rdata(arr_rdata), .bank_open(bank_open), .refresh_pulse(refresh_pulse),
    .power_down(power_down), .refresh_late(refresh_late), .self_refresh_err(self_refresh_err));
  // Record array traffic; sampling before the edge's updates keeps this race free
  always @(posedge ref_clk) begin
    if (arr_rd === 1'b1) cols.push_back({5'h00, arr_col});
    if (arr_wvalid === 1'b1 && arr_wready === 1'b1) wq.push_back(arr_wdata);
    if (refresh_pulse !== 4'h0) ref_seen = 1'b1;
  end
  // Array answers with a word derived from the column, so data is traceable
  always @(negedge ref_clk) arr_rdata <= {5'h00, arr_col} ^ 16'hA500;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic run(input int n);
    repeat (n) ctl.idle();
  endtask
  task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
    ctl.issue(c, b, a, 1'b0, 16'h0000, 1'b1);
  endtask
  // Close all banks, load a mode, reopen bank 1 at row 0x1555
  task automatic mode(input logic [12:0] m);
    cmd(CMD_PRE, 2'h0, 13'h0400);
    cmd(CMD_LMR, 2'h0, m);
    cmd(CMD_ACT, 2'h1, 13'h1555);
    run(2);
  endtask
  function automatic logic [15:0] exp_col(input int s, input int i, input int len, input int il);
    int c;
    c = il ? (s ^ i) : ((s & ~(len - 1)) | ((s + i) & (len - 1)));
    return 16'(c);
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_open();
    cmd(CMD_ACT, 2'h1, 13'h1555);
    run(3);
    chk({12'h000, bank_open}, 16'h0002);
    cmd(4'hB, 2'h2, 13'h0000); // Activate with chip deselected
    run(3);
    chk({12'h000, bank_open}, 16'h0002);
    $display("done open");
  endtask
  task automatic t_read();
    cmd(CMD_RD, 2'h1, 13'h0005);
    run(3);
    chk({15'h0000, arr_rd}, 16'h0001);
    chk({5'h00, arr_col}, 16'h0005);
    chk({3'h0, arr_row}, 16'h1555);
    chk({14'h0000, arr_bank}, 16'h0001);
    run(1);
    chk({15'h0000, dq_oe}, 16'h0001);
    chk(dq_out, 16'hA505);
    // Mask raised the cycle after the read hides that beat two clocks on
    cmd(CMD_RD, 2'h1, 13'h0005);
    ctl.issue(CMD_NOP, 2'h1, 13'h0005, 1'b1, 16'h0000, 1'b1);
    run(3);
    chk({15'h0000, dq_oe}, 16'h0000);
    // Column bits follow the organisation strap
    cfg_width = CFG_X4;
    cmd(CMD_RD, 2'h1, 13'h0805);
    run(3);
    chk({5'h00, arr_col}, 16'h0405);
    cfg_width = CFG_X8;
    cmd(CMD_RD, 2'h1, 13'h0A05);
    run(3);
    chk({5'h00, arr_col}, 16'h0205);
    cfg_width = CFG_X16;
    $display("done read");
  endtask
  // Burst lengths 1, 2, 4 and 8 in both orders, starting mid-block
  task automatic t_burst();
    int len;
    for (int bt = 0; bt < 2; bt++) begin
      for (int code = 0; code < 4; code++) begin
        mode(13'h0030 | 13'(bt << 3) | 13'(code));
        cols.delete();
        cmd(CMD_RD, 2'h1, 13'h0005);
        run(12);
        len = 1 << code;
        chk(16'(cols.size()), 16'(len));
        for (int i = 0; i < len && i < cols.size(); i++) begin
          chk(cols[i], exp_col(5, i, len, bt));
        end
      end
    end
    $display("done burst");
  endtask
  // Full page from the last column wraps, then is cut short
  task automatic t_page();
    mode(13'h0037);
    cols.delete();
    cmd(CMD_RD, 2'h1, 13'h01FF);
    run(3);
    cmd(CMD_BST, 2'h0, 13'h0000);
    run(6);
    chk(cols[1], 16'h0000);
    chk(16'(cols.size() inside {[4:5]}), 16'h0001);
    $display("done page");
  endtask
  // A read on the next cycle restarts the burst at its own column
  task automatic t_random();
    logic [15:0] ex[5] = '{16'h0002, 16'h0009, 16'h000A, 16'h000B, 16'h0008};
    mode(13'h0032);
    cols.delete();
    cmd(CMD_RD, 2'h1, 13'h0002);
    cmd(CMD_RD, 2'h1, 13'h0009);
    run(8);
    chk(16'(cols.size()), 16'h0005);
    for (int i = 0; i < 5 && i < cols.size(); i++) chk(cols[i], ex[i]);
    $display("done random");
  endtask
  task automatic t_close();
    mode(13'h0030);
    cmd(CMD_RD, 2'h1, 13'h0404);
    run(6);
    chk({12'h000, bank_open}, 16'h0000);
    cmd(CMD_ACT, 2'h0, 13'h0000);
    cmd(CMD_ACT, 2'h3, 13'h0000);
    run(1);
    cmd(CMD_PRE, 2'h0, 13'h0000);
    cmd(CMD_RD, 2'h3, 13'h0007);
    run(3);
    chk({14'h0000, arr_bank}, 16'h0003);
    chk({12'h000, bank_open}, 16'h0008);
    cmd(CMD_PRE, 2'h0, 13'h0400);
    run(3);
    chk({12'h000, bank_open}, 16'h0000);
    $display("done close");
  endtask
  // Receiver stalls: two words wait in the buffer, a masked word never arrives
  task automatic t_write();
    arr_wready = 1'b0;
    wq.delete();
    cmd(CMD_ACT, 2'h2, 13'h0000);
    run(1);
    ctl.issue(CMD_WR, 2'h2, 13'h0001, 1'b0, 16'h1234, 1'b1);
    ctl.issue(CMD_WR, 2'h2, 13'h0002, 1'b0, 16'h5678, 1'b1);
    ctl.issue(CMD_WR, 2'h2, 13'h0003, 1'b1, 16'h9999, 1'b1);
    run(5);
    chk({15'h0000, arr_wvalid}, 16'h0001);
    chk(arr_wdata, 16'h1234);
    arr_wready = 1'b1;
    run(4);
    chk(16'(wq.size()), 16'h0002);
    for (int i = 0; i < 2 && i < wq.size(); i++) chk(wq[i], i ? 16'h5678 : 16'h1234);
    $display("done write");
  endtask
  task automatic t_power();
    cmd(CMD_PRE, 2'h0, 13'h0400);
    ref_seen = 1'b0;
    cmd(CMD_REF, 2'h0, 13'h0000);
    run(4);
    chk({15'h0000, ref_seen}, 16'h0001);
    ctl.issue(CMD_NOP, 2'h0, 13'h0000, 1'b0, 16'h0000, 1'b0);
    run(3);
    chk({15'h0000, power_down}, 16'h0001);
    ctl.issue(CMD_NOP, 2'h0, 13'h0000, 1'b0, 16'h0000, 1'b1);
    run(3);
    chk({15'h0000, power_down}, 16'h0000);
    automotive_grade = 1'b1;
    ctl.issue(CMD_REF, 2'h0, 13'h0000, 1'b0, 16'h0000, 1'b0);
    ctl.issue(CMD_NOP, 2'h0, 13'h0000, 1'b0, 16'h0000, 1'b1);
    run(3);
    chk({15'h0000, self_refresh_err}, 16'h0001);
    chk({15'h0000, refresh_late}, 16'h0000);
    $display("done power");
  endtask
  // ----------------------------------------
  // Sequence and verdict
  // ----------------------------------------
  task automatic wrap_up();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    t_open();
    t_read();
    t_burst();
    t_page();
    t_random();
    t_close();
    t_write();
    t_power();
    wrap_up();
  end
  // Watchdog: the tests need a few hundred cycles, so 3000 means a hang
  initial begin
    #(3000 * 100);
    fail_count++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up();
  end
endmodule
